// >>> dbt_alu.sv
// data-alu slice: bit test, count leading bits, clear and compare
// assumes: opcode and fetched operands arrive on i_mclk, one instruction per valid cycle
`timescale 1ns/1ps
module dbt_alu (
  input  wire logic                     i_mclk,
  input  wire logic                     i_rstn,
  input  wire logic                     i_valid,
  input  wire logic [dbt_pkg::OPW-1:0]  i_opcode,
  input  wire logic                     i_pmove_class,
  input  wire logic [dbt_pkg::DW-1:0]   i_ext_word,
  input  wire logic [dbt_pkg::DW-1:0]   i_bt_operand,
  input  wire logic [dbt_pkg::DW-1:0]   i_x0,
  input  wire logic [dbt_pkg::DW-1:0]   i_y0,
  input  wire logic [dbt_pkg::DW-1:0]   i_x1,
  input  wire logic [dbt_pkg::DW-1:0]   i_y1,
  input  wire logic                     i_acc_wr,
  input  wire logic                     i_acc_wr_sel,
  input  wire logic [dbt_pkg::AW-1:0]   i_acc_wr_data,
  output logic      [dbt_pkg::AW-1:0]   o_acc_a,
  output logic      [dbt_pkg::AW-1:0]   o_acc_b,
  output logic      [7:0]               o_ccr,
  output dbt_pkg::dbt_akind_t           o_addr_kind,
  output logic                          o_mem_space,
  output logic      [15:0]              o_mem_addr,
  output logic      [5:0]               o_ea_field,
  output logic      [5:0]               o_reg_sel,
  output logic                          o_sp_dec,
  output logic                          o_done
);
  import dbt_pkg::*;

  // ****************************************************************
  // decode
  // ****************************************************************
  wire         lo_bt_w   = (i_opcode[7:0] & BT_LO_MASK) == BT_LO_VAL;
  wire         bt_ea_w   = i_valid && lo_bt_w && i_opcode[23:14] == BT_EA_HI;
  wire         bt_aa_w   = i_valid && lo_bt_w && i_opcode[23:14] == BT_AA_HI;
  wire         bt_pp_w   = i_valid && lo_bt_w && i_opcode[23:14] == BT_PP_HI;
  wire         bt_qq_w   = i_valid && lo_bt_w && i_opcode[23:14] == BT_QQ_HI;
  wire         bt_reg_w  = i_valid && lo_bt_w && i_opcode[23:14] == BT_REG_HI && i_opcode[BT_SPACE];
  wire         bt_w      = bt_ea_w | bt_aa_w | bt_pp_w | bt_qq_w | bt_reg_w;
  wire         clb_w     = i_valid && i_opcode[23:2] == CLB_HI;
  wire         clr_w     = i_valid && i_pmove_class && (i_opcode[7:0] & CLR_MASK) == CLR_VAL;
  wire         cmpr_w    = i_valid && i_pmove_class && (i_opcode[7:0] & CMPR_MASK) == CMPR_VAL;
  wire         cmps_w    = i_valid && i_opcode[23:14] == CMPS_HI && (i_opcode[7:0] & CMPI_MSK) == CMPS_LO;
  wire         cmpl_w    = i_valid && i_opcode[23:8] == CMPL_HI && (i_opcode[7:0] & CMPI_MSK) == CMPL_LO;
  wire         cmp_w     = cmpr_w | cmps_w | cmpl_w;
  wire         dsel_w    = i_opcode[ACC_SEL];
  wire [AW-1:0] acc_a_w  = o_acc_a;
  wire [AW-1:0] acc_b_w  = o_acc_b;
  wire [AW-1:0] dacc_w   = dsel_w ? acc_b_w : acc_a_w;
  wire [AW-1:0] oacc_w   = dsel_w ? acc_a_w : acc_b_w;

  // ****************************************************************
  // bit test addressing and carry
  // ****************************************************************
  wire [15:0]  pp_addr_w = PP_BASE | {10'h000, i_opcode[13:8]};
  wire [15:0]  qq_addr_w = QQ_BASE | {10'h000, i_opcode[13:8]};
  wire [15:0]  aa_addr_w = {10'h000, i_opcode[13:8]};
  wire [15:0]  bt_addr_w = bt_pp_w ? pp_addr_w : (bt_qq_w ? qq_addr_w : aa_addr_w);
  wire         bt_bit_w  = i_bt_operand[i_opcode[3:0]];
  wire         sp_hit_w  = bt_reg_w && i_opcode[13:8] == REG_SSH_SP;

  dbt_akind_t  akind_w;
  assign akind_w = bt_ea_w ? AK_EA :
                   bt_aa_w ? AK_ABS :
                   (bt_pp_w | bt_qq_w) ? AK_PER :
                   bt_reg_w ? AK_REG : AK_NONE;

  // ****************************************************************
  // count leading bits
  // ****************************************************************
  wire [AW-1:0]   clb_src_w = i_opcode[1] ? acc_b_w : acc_a_w;
  wire [CNTW-1:0] run_w;
  wire            src_zero_w = clb_src_w == ACC_RST;

  dbt_lead_count u_lead (
    .i_src (clb_src_w),
    .o_run (run_w)
  );

  wire [15:0]   clb_res_w = src_zero_w ? 16'h0000 :
                            16'(CLB_NINE - {10'h000, run_w});
  wire [AW-1:0] clb_acc_w = {{8{clb_res_w[15]}}, clb_res_w, 16'h0000};

  // ****************************************************************
  // compare
  // ****************************************************************
  wire [15:0]   imm_s_w  = {10'h000, i_opcode[13:8]};
  wire [15:0]   word_r_w = (i_opcode[6:4] == J_X0) ? i_x0 :
                           (i_opcode[6:4] == J_Y0) ? i_y0 :
                           (i_opcode[6:4] == J_X1) ? i_x1 : i_y1;
  wire [15:0]   word_w   = cmps_w ? imm_s_w : (cmpl_w ? i_ext_word : word_r_w);
  wire [AW-1:0] wide_w   = {{8{word_w[15]}}, word_w, 16'h0000};
  wire          s1acc_w  = cmpr_w && i_opcode[6:4] == J_ACC;
  wire [AW-1:0] s1_w     = s1acc_w ? oacc_w : wide_w;
  wire [AW:0]   diff_w   = {1'b0, dacc_w} - {1'b0, s1_w};
  wire          cmp_v_w  = (dacc_w[AW-1] ^ s1_w[AW-1]) & (dacc_w[AW-1] ^ diff_w[AW-1]);

  // ****************************************************************
  // flag terms
  // ****************************************************************
  wire          clb_n_w  = clb_acc_w[31];
  wire          clb_z_w  = clb_acc_w[31:16] == 16'h0000;
  wire          cmp_sc_w = diff_w[31] ^ diff_w[30];
  wire          cmp_u_w  = ~cmp_sc_w;
  wire          cmp_e_w  = ~(&diff_w[39:31] | ~|diff_w[39:31]);
  wire          cmp_z_w  = diff_w[AW-1:0] == ACC_RST;

  // ****************************************************************
  // flag update
  // ****************************************************************
  logic [7:0] ccr_w;
  always_comb begin
    ccr_w = o_ccr;
    if (bt_w) begin
      ccr_w[F_C] = bt_bit_w;
    end else if (clb_w) begin
      ccr_w[F_N] = clb_n_w;
      ccr_w[F_Z] = clb_z_w;
      ccr_w[F_V] = 1'b0;
    end else if (clr_w) begin
      ccr_w[F_E] = 1'b0;
      ccr_w[F_U] = 1'b1;
      ccr_w[F_N] = 1'b0;
      ccr_w[F_Z] = 1'b1;
      ccr_w[F_V] = 1'b0;
    end else if (cmp_w) begin
      ccr_w[F_S] = o_ccr[F_S] | cmp_sc_w;
      ccr_w[F_L] = o_ccr[F_L] | cmp_v_w;
      ccr_w[F_E] = cmp_e_w;
      ccr_w[F_U] = cmp_u_w;
      ccr_w[F_N] = diff_w[AW-1];
      ccr_w[F_Z] = cmp_z_w;
      ccr_w[F_V] = cmp_v_w;
      ccr_w[F_C] = diff_w[AW];
    end
  end

  // ****************************************************************
  // accumulator next values
  // ****************************************************************
  wire          clb_dst_w = i_opcode[0];
  wire          wr_a_w    = (clr_w && !dsel_w) || (clb_w && !clb_dst_w);
  wire          wr_b_w    = (clr_w && dsel_w) || (clb_w && clb_dst_w);
  wire [AW-1:0] res_w     = clr_w ? ACC_RST : clb_acc_w;
  wire [AW-1:0] acc_a_d   = wr_a_w ? res_w :
                            (i_acc_wr && !i_acc_wr_sel) ? i_acc_wr_data : o_acc_a;
  wire [AW-1:0] acc_b_d   = wr_b_w ? res_w :
                            (i_acc_wr && i_acc_wr_sel) ? i_acc_wr_data : o_acc_b;

  // ****************************************************************
  // address and pulse next values
  // ****************************************************************
  wire [5:0]    fld_w     = i_opcode[13:8];
  wire          space_d   = i_opcode[BT_SPACE] & ~bt_reg_w;
  wire [5:0]    reg_sel_d = bt_reg_w ? fld_w : 6'h00;
  wire          done_d    = bt_w | clb_w | clr_w | cmp_w;

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_acc_a     <= ACC_RST;
      o_acc_b     <= ACC_RST;
      o_ccr       <= CCR_RST;
    end else begin
      o_acc_a     <= acc_a_d;
      o_acc_b     <= acc_b_d;
      o_ccr       <= ccr_w;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_addr_kind <= AK_NONE;
      o_mem_space <= 1'b0;
      o_mem_addr  <= ADDR_RST;
      o_ea_field  <= 6'h00;
      o_reg_sel   <= 6'h00;
    end else begin
      o_addr_kind <= akind_w;
      o_mem_space <= space_d;
      o_mem_addr  <= bt_addr_w;
      o_ea_field  <= fld_w;
      o_reg_sel   <= reg_sel_d;
    end
  end

  // ****************************************************************
  // one-cycle pulses
  // ****************************************************************
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_sp_dec    <= 1'b0;
      o_done      <= 1'b0;
    end else begin
      o_sp_dec    <= sp_hit_w;
      o_done      <= done_d;
    end
  end

endmodule : dbt_alu

// >>> dbt_pkg.sv
// package: opcode patterns, field positions, flag positions and reset values
// assumes: 24-bit opcode words, 16-bit data words, 40-bit accumulators
package dbt_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int unsigned OPW  = 24;
  localparam int unsigned DW   = 16;
  localparam int unsigned AW   = 40;
  localparam int unsigned CNTW = 6;

  // ****************************************************************
  // condition code flag positions
  // ****************************************************************
  localparam int unsigned F_C = 0;
  localparam int unsigned F_V = 1;
  localparam int unsigned F_Z = 2;
  localparam int unsigned F_N = 3;
  localparam int unsigned F_U = 4;
  localparam int unsigned F_E = 5;
  localparam int unsigned F_L = 6;
  localparam int unsigned F_S = 7;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0]    CCR_RST  = 8'h00;
  localparam logic [AW-1:0] ACC_RST  = 40'h00_0000_0000;
  localparam logic [15:0]   ADDR_RST = 16'h0000;

  // ****************************************************************
  // bit test forms: opcode bits 23..14 and low-byte fixed bits
  // ****************************************************************
  localparam logic [9:0]  BT_EA_HI   = 10'h02d;
  localparam logic [9:0]  BT_AA_HI   = 10'h02c;
  localparam logic [9:0]  BT_PP_HI   = 10'h02e;
  localparam logic [9:0]  BT_QQ_HI   = 10'h005;
  localparam logic [9:0]  BT_REG_HI  = 10'h02f;
  localparam logic [7:0]  BT_LO_MASK = 8'hb0;
  localparam logic [7:0]  BT_LO_VAL  = 8'h20;
  localparam int unsigned BT_SPACE   = 6;
  localparam logic [15:0] PP_BASE    = 16'hffc0;
  localparam logic [15:0] QQ_BASE    = 16'hff80;
  localparam logic [5:0]  REG_SSH_SP = 6'h3c;

  // ****************************************************************
  // count leading bits: bits 23..2 fixed, bit 1 source, bit 0 dest
  // ****************************************************************
  localparam logic [21:0] CLB_HI = 22'h03_07e0;
  localparam logic [15:0] CLB_NINE = 16'h0009;

  // ****************************************************************
  // parallel-move class forms: low byte patterns
  // ****************************************************************
  localparam logic [7:0] CLR_MASK  = 8'hf7;
  localparam logic [7:0] CLR_VAL   = 8'h13;
  localparam logic [7:0] CMPR_MASK = 8'h87;
  localparam logic [7:0] CMPR_VAL  = 8'h05;
  localparam int unsigned ACC_SEL  = 3;

  // ****************************************************************
  // compare source one select codes
  // ****************************************************************
  localparam logic [2:0] J_ACC = 3'h0;
  localparam logic [2:0] J_X0  = 3'h4;
  localparam logic [2:0] J_Y0  = 3'h5;
  localparam logic [2:0] J_X1  = 3'h6;
  localparam logic [2:0] J_Y1  = 3'h7;

  // ****************************************************************
  // immediate compare forms
  // ****************************************************************
  localparam logic [9:0]  CMPS_HI  = 10'h005;
  localparam logic [7:0]  CMPS_LO  = 8'h85;
  localparam logic [15:0] CMPL_HI  = 16'h0140;
  localparam logic [7:0]  CMPL_LO  = 8'hc5;
  localparam logic [7:0]  CMPI_MSK = 8'hf7;

  // ****************************************************************
  // operand address kinds
  // ****************************************************************
  typedef enum logic [4:0] {
    AK_NONE = 5'b00001,
    AK_EA   = 5'b00010,
    AK_ABS  = 5'b00100,
    AK_PER  = 5'b01000,
    AK_REG  = 5'b10000
  } dbt_akind_t;

endpackage : dbt_pkg

// >>> dbt_lead_count.sv
// leading-bit run counter over a 40-bit accumulator value
// assumes: purely combinational, used inside the core clock domain
`timescale 1ns/1ps
module dbt_lead_count (
  input  wire logic [dbt_pkg::AW-1:0]   i_src,
  output logic      [dbt_pkg::CNTW-1:0] o_run
);
  import dbt_pkg::*;

  logic [AW-2:0] diff_w;
  logic [AW-2:0] run_w;

  // ****************************************************************
  // per-bit run chain downward from bit 39
  // ****************************************************************
  assign diff_w = i_src[AW-2:0] ^ {(AW-1){i_src[AW-1]}};

  genvar g;
  generate
    for (g = 0; g < AW - 1; g++) begin : g_run
      if (g == AW - 2) begin : g_top
        assign run_w[g] = ~diff_w[g];
      end else begin : g_rest
        assign run_w[g] = run_w[g+1] & ~diff_w[g];
      end
    end
  endgenerate

  always_comb begin
    o_run = CNTW'(1);
    for (int k = 0; k < AW - 1; k++) begin
      o_run = o_run + CNTW'(run_w[k]);
    end
  end

endmodule : dbt_lead_count

// >>> dbt_alu_props.sv
// checker: port-level timing and value relations of the data-alu slice
// assumes: bound into dbt_alu, single clock i_mclk, async active-low i_rstn
`timescale 1ns/1ps
module dbt_alu_props
  import dbt_pkg::*;
(
  input wire logic                    i_mclk,
  input wire logic                    i_rstn,
  input wire logic                    i_valid,
  input wire logic [dbt_pkg::OPW-1:0] i_opcode,
  input wire logic                    i_pmove_class,
  input wire logic [dbt_pkg::DW-1:0]  i_bt_operand,
  input wire logic                    i_acc_wr,
  input wire logic [dbt_pkg::AW-1:0]  o_acc_a,
  input wire logic [dbt_pkg::AW-1:0]  o_acc_b,
  input wire logic [7:0]              o_ccr,
  input wire dbt_pkg::dbt_akind_t     o_addr_kind,
  input wire logic                    o_mem_space,
  input wire logic [15:0]             o_mem_addr,
  input wire logic                    o_sp_dec
);
  // ****************************************************************
  // decode helpers
  // ****************************************************************
  wire logic [5:0] fld    = i_opcode[13:8];
  wire logic       spc    = i_opcode[BT_SPACE];
  wire logic       dsel   = i_opcode[ACC_SEL];
  wire logic       bt_bit = i_bt_operand[i_opcode[3:0]];
  wire logic       bt_lo  = i_valid && ((i_opcode[7:0] & BT_LO_MASK) == BT_LO_VAL);
  wire logic       pp_hit = bt_lo && (i_opcode[23:14] == BT_PP_HI);
  wire logic       qq_hit = bt_lo && (i_opcode[23:14] == BT_QQ_HI);
  wire logic       rg_hit = bt_lo && (i_opcode[23:14] == BT_REG_HI) && spc;
  wire logic       bt_hit = pp_hit || qq_hit || rg_hit || (bt_lo && (i_opcode[23:14] inside {BT_EA_HI, BT_AA_HI}));
  wire logic       sp_hit = rg_hit && (fld == REG_SSH_SP);
  wire logic       clb_hit = i_valid && (i_opcode[23:2] == CLB_HI);
  wire logic       clr_hit = i_valid && i_pmove_class && ((i_opcode[7:0] & CLR_MASK) == CLR_VAL);
  wire logic       cmp_hit = i_valid && ((i_pmove_class && ((i_opcode[7:0] & CMPR_MASK) == CMPR_VAL))
    || (i_opcode[23:14] == CMPS_HI && (i_opcode[7:0] & CMPI_MSK) == CMPS_LO)
    || (i_opcode[23:8] == CMPL_HI && (i_opcode[7:0] & CMPI_MSK) == CMPL_LO));

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  chk_bt_carry: assert property (bt_hit |=> o_ccr[F_C] == $past(bt_bit)) else $error("carry not tested bit");
  chk_bt_space: assert property (bt_hit && !rg_hit |=> o_mem_space == $past(spc)) else $error("memory space wrong");
  chk_pp_addr: assert property (pp_hit |=> o_addr_kind == AK_PER && o_mem_addr == (PP_BASE | {10'h0, $past(fld)}))
    else $error("top block address wrong");
  chk_qq_addr: assert property (qq_hit |=> o_addr_kind == AK_PER && o_mem_addr == (QQ_BASE | {10'h0, $past(fld)}))
    else $error("lower block address wrong");
  chk_reg_kind: assert property (rg_hit |=> o_addr_kind == AK_REG && !o_mem_space) else $error("register form wrong");
  chk_sp_pulse: assert property (o_sp_dec == $past(sp_hit)) else $error("stack pointer pulse wrong");
  chk_clb_layout: assert property (clb_hit && !i_opcode[0] |=> o_acc_a[15:0] == 16'h0 && o_acc_a[39:32] == {8{o_acc_a[31]}})
    else $error("count layout wrong");
  chk_clb_flags: assert property (clb_hit |=> !o_ccr[F_V] && $stable(o_ccr[F_C]) && $stable(o_ccr[7:4]))
    else $error("count flags wrong");
  chk_clr_zero: assert property (clr_hit |=> ($past(dsel) ? o_acc_b : o_acc_a) == 40'h0) else $error("clear left bits");
  chk_clr_flags: assert property (clr_hit |=> o_ccr[5:1] == 5'b01010 && $stable(o_ccr[F_C]))
    else $error("clear flags wrong");
  chk_cmp_keep: assert property (cmp_hit && !i_acc_wr |=> $stable(o_acc_a) && $stable(o_acc_b))
    else $error("compare altered accumulator");
endmodule : dbt_alu_props

bind dbt_alu dbt_alu_props u_props (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_valid(i_valid), .i_opcode(i_opcode),
  .i_pmove_class(i_pmove_class), .i_bt_operand(i_bt_operand), .i_acc_wr(i_acc_wr), .o_acc_a(o_acc_a),
  .o_acc_b(o_acc_b), .o_ccr(o_ccr), .o_addr_kind(o_addr_kind), .o_mem_space(o_mem_space),
  .o_mem_addr(o_mem_addr), .o_sp_dec(o_sp_dec));

// >>> dbt_alu_tb.sv
// testbench: bit test, count leading bits, clear and compare through the ports
// assumes: dbt_alu with latency 1, inputs driven 10 ns after each rising edge
`timescale 1ns/1ps
module dbt_alu_tb;
  import dbt_pkg::*;
  logic              i_mclk, i_rstn, i_valid, i_pmove_class, i_acc_wr, i_acc_wr_sel;
  logic [OPW-1:0]    i_opcode;
  logic [DW-1:0]     i_ext_word, i_bt_operand, i_x0, i_y0, i_x1, i_y1;
  logic [AW-1:0]     i_acc_wr_data, o_acc_a, o_acc_b;
  logic [7:0]        o_ccr, xc;
  dbt_akind_t        o_addr_kind;
  logic              o_mem_space, o_sp_dec, o_done;
  logic [15:0]       o_mem_addr;
  logic [5:0]        o_ea_field, o_reg_sel;
  int                error_cnt = 0;
  int                cmp_count = 0;

  dbt_alu dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_valid(i_valid), .i_opcode(i_opcode),
    .i_pmove_class(i_pmove_class), .i_ext_word(i_ext_word), .i_bt_operand(i_bt_operand), .i_x0(i_x0),
    .i_y0(i_y0), .i_x1(i_x1), .i_y1(i_y1), .i_acc_wr(i_acc_wr), .i_acc_wr_sel(i_acc_wr_sel),
    .i_acc_wr_data(i_acc_wr_data), .o_acc_a(o_acc_a), .o_acc_b(o_acc_b), .o_ccr(o_ccr),
    .o_addr_kind(o_addr_kind), .o_mem_space(o_mem_space), .o_mem_addr(o_mem_addr), .o_ea_field(o_ea_field),
    .o_reg_sel(o_reg_sel), .o_sp_dec(o_sp_dec), .o_done(o_done));

  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task chk(input logic [AW-1:0] seen, input logic [AW-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task tally_and_finish;
    if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  task step(input logic [OPW-1:0] op, input logic pm);
    @(posedge i_mclk);
    #10;
    i_opcode = op;
    i_pmove_class = pm;
    i_valid = 1'b1;
    @(posedge i_mclk);
    #10;
    i_valid = 1'b0;
    i_acc_wr = 1'b0;
  endtask : step

  task load(input logic sel, input logic [AW-1:0] d);
    @(posedge i_mclk);
    #10;
    i_acc_wr = 1'b1;
    i_acc_wr_sel = sel;
    i_acc_wr_data = d;
    @(posedge i_mclk);
    #10;
    i_acc_wr = 1'b0;
  endtask : load

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_bt;
    logic [9:0]  hi [5];
    dbt_akind_t  kd [5];
    logic [5:0]  fl;
    logic        sp;
    hi = '{BT_EA_HI, BT_AA_HI, BT_PP_HI, BT_QQ_HI, BT_REG_HI};
    kd = '{AK_EA, AK_ABS, AK_PER, AK_PER, AK_REG};
    for (int f = 0; f < 5; f++) begin
      for (int s = 0; s < 2; s++) begin
        fl = s ? REG_SSH_SP : 6'h2a;
        sp = (f == 4) ? 1'b0 : s[0];
        i_bt_operand = s ? 16'h8000 : 16'hfff7;
        step({hi[f], fl, 1'b0, sp | (f == 4), 2'b10, s ? 4'hf : 4'h3}, 1'b0);
        xc[F_C] = s[0];
        chk(o_ccr, xc);
        chk(o_addr_kind, kd[f]);
        chk(o_mem_space, sp);
        chk(o_reg_sel, (f == 4) ? fl : 6'h0);
        chk(o_sp_dec, f == 4 && s == 1);
        chk(o_ea_field, fl);
        chk(o_done, 1'b1);
        if (f inside {[1:3]}) chk(o_mem_addr, (f == 1) ? {10'h0, fl} : (f == 2 ? PP_BASE : QQ_BASE) | fl);
      end
    end
  endtask : t_bt

  task t_clb;
    logic [AW-1:0] sv [6];
    logic [15:0]   r;
    int            run;
    sv = '{40'h0, 40'h1, 40'h80_0000_0000, 40'hff_ffff_ffff, 40'h00_8000_0000, 40'h00_4000_0000};
    foreach (sv[i]) begin
      run = 0;
      while (run < 40 && sv[i][39-run] == sv[i][39]) run++;
      r = (sv[i] == '0) ? 16'h0 : CLB_NINE - 16'(run);
      load(i[1], sv[i]);
      load(!i[1], 40'h12_3456_789a);
      step({CLB_HI, i[1], i[0]}, 1'b0);
      xc[F_N] = r[15];
      xc[F_Z] = (r == 16'h0);
      xc[F_V] = 1'b0;
      chk(i[0] ? o_acc_b : o_acc_a, {{8{r[15]}}, r, 16'h0});
      chk(o_ccr, xc);
      if (i[0] != i[1]) chk(i[1] ? o_acc_b : o_acc_a, sv[i]);
    end
  endtask : t_clb

  task t_clr;
    for (int d = 0; d < 2; d++) begin
      load(1'b0, 40'h11_2233_4455);
      load(1'b1, 40'hf0_0000_0001);
      @(posedge i_mclk);
      #10;
      i_acc_wr = 1'b1;
      i_acc_wr_sel = 1'b1;
      i_acc_wr_data = 40'h0a_bcde_f012;
      step({16'h5a5a, 4'h1, d[0], 3'b011}, 1'b1);
      xc[5:1] = 5'b01010;
      chk(o_acc_a, d ? 40'h11_2233_4455 : 40'h0);
      chk(o_acc_b, d ? 40'h0 : 40'h0a_bcde_f012);
      chk(o_ccr, xc);
    end
  endtask : t_clr

  task t_cmp;
    logic [2:0]    jc [5];
    logic [15:0]   wv [7];
    logic [AW-1:0] av [2];
    logic [AW-1:0] ac, s1, df;
    logic [AW:0]   d41;
    jc = '{J_ACC, J_X0, J_Y0, J_X1, J_Y1};
    wv = '{16'h0, i_x0, i_y0, i_x1, i_y1, 16'h003f, i_ext_word};
    av = '{40'h00_1234_0000, 40'hff_8000_0000};
    load(1'b0, av[0]);
    load(1'b1, av[1]);
    for (int k = 0; k < 7; k++) begin
      for (int d = 0; d < 2; d++) begin
        ac = av[d];
        s1 = k ? {{8{wv[k][15]}}, wv[k], 16'h0} : av[1-d];
        d41 = {1'b0, ac} - {1'b0, s1};
        df = d41[AW-1:0];
        xc[F_C] = d41[AW];
        xc[F_V] = (ac[39] != s1[39]) && (df[39] != ac[39]);
        xc[F_Z] = (df == '0);
        xc[F_N] = df[39];
        xc[F_U] = !(df[31] ^ df[30]);
        xc[F_E] = !(&df[39:31] || ~|df[39:31]);
        xc[F_S] = xc[F_S] | (df[31] ^ df[30]);
        xc[F_L] = xc[F_L] | xc[F_V];
        step(k == 5 ? {CMPS_HI, 6'h3f, 4'h8, d[0], 3'b101} : k == 6 ? {CMPL_HI, 4'hc, d[0], 3'b101}
          : {17'h0, jc[k], d[0], 3'b101}, k < 5);
        chk(o_ccr, xc);
        chk(o_acc_a, av[0]);
        chk(o_acc_b, av[1]);
        chk(o_done, 1'b1);
      end
    end
    step(24'hffffff, 1'b0);
    chk(o_done, 1'b0);
    chk(o_ccr, xc);
  endtask : t_cmp

  initial begin
    #(100 * 5000);
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    {i_rstn, i_valid, i_pmove_class, i_acc_wr, i_acc_wr_sel} = 5'h0;
    i_opcode = 24'h0;
    i_acc_wr_data = 40'h0;
    i_bt_operand = 16'h0;
    i_x0 = 16'h1234;
    i_y0 = 16'h8000;
    i_x1 = 16'h7fff;
    i_y1 = 16'hffff;
    i_ext_word = 16'h8001;
    xc = CCR_RST;
    repeat (5) @(posedge i_mclk);
    #10;
    i_rstn = 1'b1;
    chk(o_ccr, CCR_RST);
    chk(o_addr_kind, AK_NONE);
    t_bt();
    t_clb();
    t_clr();
    t_cmp();
    tally_and_finish();
  end
endmodule : dbt_alu_tb
